// *** pkg/aacs_pkg.sv ***
package aacs_pkg;
	// trigger source encodings
	localparam logic [1:0] AACS_TRIG_SOFT0 = 2'h0;
	localparam logic [1:0] AACS_TRIG_TMR1 = 2'h1;
	localparam logic [1:0] AACS_TRIG_TMR2 = 2'h2;
	localparam logic [1:0] AACS_TRIG_SELF = 2'h3;
	// count field: 000 is manual mode
	localparam logic [2:0] AACS_CNT_MANUAL = 3'h0;
	localparam int AACS_RES_W = 12;
	localparam int AACS_ACC_W = 16;
	localparam logic [AACS_RES_W-1:0] AACS_FULL_SCALE = 12'hfff;
	// conversion length in clocks, and interval unit in clocks
	localparam int AACS_CONV_CYC = 16;
	localparam int AACS_IVL_UNIT = 4;
	localparam int AACS_TMR_W = 8;
	localparam logic [AACS_TMR_W-1:0] AACS_TMR_ONE = 8'h01;

	typedef enum logic [4:0] {
		AACS_IDLE = 5'b00001,
		AACS_CH1 = 5'b00010,
		AACS_GAP1 = 5'b00100,
		AACS_CH2 = 5'b01000,
		AACS_GAP2 = 5'b10000
	} aacs_state_t;

	typedef struct packed {
		logic power_on;
		logic auto_start;
		logic [1:0] trig_src;
		logic [2:0] count_sel;
		logic [3:0] interval_sel;
		logic start_bit;
		logic irq_clear;
	} aacs_ctrl_t;

	typedef struct packed {
		aacs_state_t st;
		logic [AACS_TMR_W-1:0] tmr;
		logic [4:0] cycles;
		logic [AACS_ACC_W-1:0] acc;
		logic busy;
		logic irq_flag;
		logic overrun;
		logic auto_run;
		logic auto_prev;
		logic start_prev;
		logic manual;
		logic stop_pend;
		logic man_done;
		logic [7:0] res_lo;
		logic [7:0] res_hi;
		logic irq;
	} aacs_regs_t;
endpackage

// *** rtl/aacs_seq.sv ***
// Operation
// R1 - self-timed: auto start rising clears overrun and converts first channel now
// R2 - after first channel, wait selected interval then convert second channel
// R3 - after second channel and interval, start next first/second cycle
// R4 - after N cycles clear auto start and set interrupt flag
// R5 - count field picks N of 1,2,4,8,16; nonzero means automatic
// R6 - sources 00/11: clear while busy defers reset until conversion ends
// R7 - auto start accepted again only after sequencer reset finished
// R8 - sources 01/10: software waits busy low, one manual conversion, then reselects
// R9 - sources 01/10: reset sequencer after manual conversion and auto reselected
// R10 - clear after all conversions done still raises interrupt
// R11 - manual mode: start pulse low-high-low begins a conversion
// R12 - power bit low switches conversion circuitry off
// R13 - results are 12-bit unsigned, full scale is all ones
// R14 - busy set during conversion, clear when it ends
// R15 - result presented as low byte and high byte
// R16 - end of conversion sets flag; irq needs local and global enable
// R17 - automatic group accumulates values, holds final sum
// R18 - further auto start ignored until N cycles (2N conversions) finished
// R19 - self-timed clear while idle resets sequencer at once
// R20 - busy rises with start and falls with result update
`timescale 1ns/1ps
`default_nettype none
module aacs_seq
	import aacs_pkg::*;
#(
	parameter int CONV_CYC = AACS_CONV_CYC,
	parameter int IVL_UNIT = AACS_IVL_UNIT
) (
	input wire logic sys_clk_in, // 250 MHz clock
	input wire logic reset_n_in, // sync reset, active low
	input wire aacs_ctrl_t ctrl_in, // software control bits
	input wire logic conv_irq_enable_in, // local irq enable
	input wire logic global_irq_enable_in, // global irq enable
	input wire logic [AACS_RES_W-1:0] sample_in, // converter sample, synchronised
	output logic conv_busy_flag_out, // conversion in progress
	output logic conv_irq_flag_out, // sticky end of conversion flag
	output logic trigger_overrun_flag_out, // overrun flag
	output logic auto_conv_start_out, // automatic start bit state
	output logic [7:0] result_low_byte_out, // result low byte
	output logic [7:0] result_high_byte_out, // result high byte
	output logic conv_irq_out, // interrupt request
	output logic analog_on_out // analog circuitry power
);
	aacs_regs_t r, nxt;
	logic [AACS_RES_W-1:0] smp_meta, smp_sync;
	logic [4:0] n_target;
	logic auto_mode, start_rise, auto_rise, conv_end, sw_clear;
	logic analog_on_r;

	// two-flop sampling of the analog result bus
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			smp_meta <= '0;
			smp_sync <= '0;
		end else begin
			smp_meta <= sample_in;
			smp_sync <= smp_meta;
		end
	end

	// count field decode, 1..16; codes above 4 saturate at 16
	always_comb begin
		case (ctrl_in.count_sel)
			3'h1: n_target = 5'h01; // R5
			3'h2: n_target = 5'h02;
			3'h3: n_target = 5'h04;
			3'h4: n_target = 5'h08;
			default: n_target = 5'h10;
		endcase
	end

	assign auto_mode = ctrl_in.count_sel != AACS_CNT_MANUAL; // R5
	assign start_rise = ctrl_in.start_bit & ~r.start_prev;
	assign auto_rise = ctrl_in.auto_start & ~r.auto_prev;
	assign conv_end = r.busy && r.tmr == AACS_TMR_ONE;
	assign sw_clear = ~ctrl_in.auto_start & r.auto_prev & r.auto_run;

	// next-state logic for the whole sequencer
	always_comb begin
		logic [AACS_ACC_W-1:0] sum;
		logic timed;
		sum = '0;
		timed = ctrl_in.trig_src == AACS_TRIG_SOFT0 || ctrl_in.trig_src == AACS_TRIG_SELF;
		nxt = r;
		nxt.auto_prev = ctrl_in.auto_start;
		// start pulse taken on the falling edge after a high
		nxt.start_prev = ctrl_in.start_bit;
		if (r.tmr != '0) begin
			nxt.tmr = r.tmr - AACS_TMR_ONE;
		end
		if (ctrl_in.irq_clear) begin
			nxt.irq_flag = 1'b0;
		end
		// conversion end: result, accumulate, busy drop in one cycle
		if (conv_end) begin
			nxt.busy = 1'b0; // R14 R20
			nxt.irq_flag = !r.auto_run || r.manual ? 1'b1 : r.irq_flag; // R16
			if (r.auto_run && !r.manual) begin
				sum = r.acc + {{(AACS_ACC_W-AACS_RES_W){1'b0}}, smp_sync}; // R17
				nxt.acc = sum;
			end else begin
				sum = {{(AACS_ACC_W-AACS_RES_W){1'b0}}, smp_sync}; // R13
			end
			nxt.res_lo = sum[7:0]; // R15
			nxt.res_hi = sum[15:8];
			if (r.manual) begin
				nxt.manual = 1'b0;
				nxt.man_done = 1'b1;
			end
		end
		// manual conversion, low-high-low on start
		if (!auto_mode && !r.busy && !r.start_prev && start_rise && ctrl_in.power_on) begin
			nxt.manual = 1'b1; // R11
		end
		if (r.manual && !r.busy && !ctrl_in.start_bit && r.start_prev) begin
			nxt.busy = 1'b1; // R11 R20
			nxt.tmr = AACS_TMR_W'(CONV_CYC);
		end
		case (r.st)
			AACS_IDLE: begin
				// R18: only a fresh rising edge launches, while idle
				if (auto_rise && auto_mode && ctrl_in.power_on && !r.busy) begin
					nxt.overrun = 1'b0; // R1
					nxt.auto_run = 1'b1; // R7
					nxt.cycles = '0;
					nxt.acc = '0;
					nxt.st = AACS_CH1; // R1
					nxt.busy = 1'b1; // R20
					nxt.tmr = AACS_TMR_W'(CONV_CYC);
				end
			end
			AACS_CH1: begin
				if (conv_end) begin
					nxt.st = AACS_GAP1; // R2
					nxt.tmr = AACS_TMR_W'(({4'h0, ctrl_in.interval_sel} + 8'h01) * IVL_UNIT);
				end
			end
			AACS_GAP1: begin
				if (r.tmr == AACS_TMR_ONE) begin
					nxt.st = AACS_CH2; // R2
					nxt.busy = 1'b1;
					nxt.tmr = AACS_TMR_W'(CONV_CYC);
				end
			end
			AACS_CH2: begin
				if (conv_end) begin
					nxt.cycles = r.cycles + 5'h01;
					if (r.cycles + 5'h01 == n_target) begin
						nxt.st = AACS_IDLE; // R4
						nxt.auto_run = 1'b0;
						nxt.irq_flag = 1'b1; // R4
					end else begin
						nxt.st = AACS_GAP2; // R3
						nxt.tmr = AACS_TMR_W'(({4'h0, ctrl_in.interval_sel} + 8'h01) * IVL_UNIT);
					end
				end
			end
			AACS_GAP2: begin
				if (r.tmr == AACS_TMR_ONE) begin
					nxt.st = AACS_CH1; // R3
					nxt.busy = 1'b1;
					nxt.tmr = AACS_TMR_W'(CONV_CYC);
				end
			end
			default: nxt.st = AACS_IDLE;
		endcase
		// software stop of a running group
		if (sw_clear || r.stop_pend) begin
			if (timed) begin
				if (r.busy && !conv_end) begin
					nxt.stop_pend = 1'b1; // R6
				end else begin
					nxt.st = AACS_IDLE; // R19 R6
					nxt.auto_run = 1'b0;
					nxt.stop_pend = 1'b0;
					nxt.busy = 1'b0;
					nxt.tmr = '0;
				end
			end else begin
				nxt.stop_pend = 1'b1; // R9 waits for manual conversion
				nxt.auto_run = r.st != AACS_IDLE && r.auto_run;
			end
		end
		// timer sources: reset once manual done and automatic reselected
		if (!timed && r.stop_pend && r.man_done && auto_mode) begin
			nxt.st = AACS_IDLE; // R9
			nxt.auto_run = 1'b0;
			nxt.stop_pend = 1'b0;
			nxt.man_done = 1'b0;
		end
		if (!timed && r.stop_pend && !r.busy && !r.manual && !auto_mode) begin
			nxt.st = AACS_IDLE; // R8 sequencer parked during manual step
		end
		// stop in the same cycle the last conversion finishes still flags
		if (sw_clear && r.st == AACS_CH2 && conv_end && r.cycles + 5'h01 == n_target) begin
			nxt.irq_flag = 1'b1; // R10
		end
		// power down: everything analog halts
		if (!ctrl_in.power_on) begin
			nxt.st = AACS_IDLE; // R12
			nxt.busy = 1'b0;
			nxt.manual = 1'b0;
			nxt.auto_run = 1'b0;
			nxt.stop_pend = 1'b0;
			nxt.tmr = '0;
		end
		nxt.irq = nxt.irq_flag & conv_irq_enable_in & global_irq_enable_in; // R16
	end

	// single state register
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			r <= '{st: AACS_IDLE, default: '0};
		end else begin
			r <= nxt;
		end
	end

	assign conv_busy_flag_out = r.busy;
	assign conv_irq_flag_out = r.irq_flag;
	assign trigger_overrun_flag_out = r.overrun;
	assign auto_conv_start_out = r.auto_run; // R4
	assign result_low_byte_out = r.res_lo;
	assign result_high_byte_out = r.res_hi;
	assign conv_irq_out = r.irq;
	assign analog_on_out = analog_on_r;

	// analog power from next state, so the enable is registered with no lag
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			analog_on_r <= 1'b0;
		end else begin
			analog_on_r <= ctrl_in.power_on & (nxt.busy | nxt.auto_run); // R12
		end
	end

	// busy holds for at least two cycles after it rises
	busy_len_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R14
		$rose(r.busy) && ctrl_in.power_on |-> r.busy [*2])
		else $error("busy pulse too short");
	// first channel starts the cycle after launch
	launch_ch1_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R1
		r.st == AACS_IDLE && auto_rise && auto_mode && ctrl_in.power_on && !r.busy
		&& ctrl_in.auto_start |=> r.st == AACS_CH1 && r.busy && !r.overrun)
		else $error("launch did not start first channel");
	// first interval never busy
	gap_idle_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R2
		r.st == AACS_GAP1 |-> !r.busy)
		else $error("busy during interval");
	// power off clears activity
	power_off_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R12
		!ctrl_in.power_on |=> !r.busy && r.st == AACS_IDLE)
		else $error("active while powered off");
	// irq only with flag set
	irq_gate_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R16
		r.irq |-> r.irq_flag)
		else $error("irq without flag");
	// irq only when both enables were set as it was registered
	irq_both_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R16
		r.irq |-> $past(conv_irq_enable_in && global_irq_enable_in))
		else $error("irq without both enables");
	// last second-channel conversion ends the group and flags it
	done_flag_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R4
		r.st == AACS_CH2 && conv_end && r.cycles + 5'h01 == n_target && ctrl_in.power_on
		|=> !r.auto_run && r.irq_flag)
		else $error("group end not flagged");
	// second interval is never busy
	gap2_idle_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R3
		r.st == AACS_GAP2 |-> !r.busy)
		else $error("busy during second interval");
	// self-timed stop while busy is deferred, not taken at once
	stop_defer_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R6
		sw_clear && ctrl_in.trig_src == AACS_TRIG_SELF && r.busy && !conv_end
		&& ctrl_in.power_on |=> r.stop_pend)
		else $error("stop not deferred");
	// self-timed stop while idle resets at once
	idle_stop_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R19
		sw_clear && ctrl_in.trig_src == AACS_TRIG_SELF && !r.busy
		|=> r.st == AACS_IDLE && !r.auto_run)
		else $error("idle stop not immediate");
	// result bytes change only at a conversion end
	result_hold_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R15
		!conv_end |=> $stable({r.res_hi, r.res_lo}))
		else $error("result changed without conversion");
	// falling start edge of an armed manual pulse launches a conversion
	manual_start_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R11
		r.manual && !r.busy && !ctrl_in.start_bit && r.start_prev && ctrl_in.power_on
		|=> r.busy)
		else $error("manual pulse did not start");
endmodule
`default_nettype wire

// *** verif/tb_aacs_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_aacs_seq;
	import aacs_pkg::*;
	logic sys_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	aacs_ctrl_t ctrl = '0;
	logic ie = 1'b0;
	logic ge = 1'b0;
	logic [11:0] smp = 12'h000;
	logic busy, flag, ovr, ast, irq, aon;
	logic [7:0] lo, hi;
	int err_total = 0;
	int total_checks = 0;
	int g0, g1;
	// 4 ns period
	always #2 sys_clk_in = ~sys_clk_in;
	aacs_seq #(.CONV_CYC(16), .IVL_UNIT(4)) uut (.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in), .ctrl_in(ctrl), .conv_irq_enable_in(ie),
		.global_irq_enable_in(ge), .sample_in(smp), .conv_busy_flag_out(busy),
		.conv_irq_flag_out(flag), .trigger_overrun_flag_out(ovr),
		.auto_conv_start_out(ast), .result_low_byte_out(lo),
		.result_high_byte_out(hi), .conv_irq_out(irq), .analog_on_out(aon));
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	// waits under a bound so a dead sequencer cannot hang the run
	task automatic wait_rise(output int n);
		n = 0;
		while (busy !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
	endtask
	task automatic conv_len(input int exp_n);
		int n;
		n = 0;
		while (busy === 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		chk("conversion length", 16'(n), 16'(exp_n));
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic t_reset();
		chk("flags after reset", {busy, flag, ovr, ast, irq, 11'h000}, 16'h0000);
		chk("result after reset", {hi, lo}, 16'h0000);
		ctrl.power_on <= 1'b0;
		tick(2);
		chk("analog power off", {15'h0000, aon}, 16'h0000);
		$display("test reset done");
	endtask
	// manual pulse, full-scale sample, both enables on
	task automatic t_manual();
		int n;
		@(posedge sys_clk_in);
		ctrl.power_on <= 1'b1;
		ctrl.count_sel <= AACS_CNT_MANUAL;
		smp <= AACS_FULL_SCALE;
		ie <= 1'b1;
		ge <= 1'b1;
		tick(4);
		ctrl.start_bit <= 1'b1;
		@(posedge sys_clk_in);
		ctrl.start_bit <= 1'b0;
		wait_rise(n);
		chk("manual launch", 16'(n < 5), 16'd1);
		conv_len(16);
		chk("result bytes", {hi, lo}, 16'h0fff);
		tick(1);
		chk("flag and irq", {14'h0000, flag, irq}, 16'h0003);
		ctrl.irq_clear <= 1'b1;
		tick(1);
		ctrl.irq_clear <= 1'b0;
		tick(2);
		chk("flag cleared", {15'h0000, flag}, 16'h0000);
		$display("test manual done");
	endtask
	// self-timed group; returns the first gap between conversions
	task automatic t_auto(input logic [2:0] cs, input logic [3:0] iv, input int nc,
		input logic [15:0] sum, output int gap);
		int n;
		@(posedge sys_clk_in);
		ctrl.trig_src <= AACS_TRIG_SELF;
		ctrl.count_sel <= cs;
		ctrl.interval_sel <= iv;
		smp <= 12'h800;
		ge <= 1'b0;
		tick(4);
		ctrl.auto_start <= 1'b1;
		wait_rise(n);
		chk("auto launch", 16'(n < 4), 16'd1);
		chk("overrun cleared", {15'h0000, ovr}, 16'h0000);
		for (int i = 0; i < nc; i++) begin
			conv_len(16);
			if (i < nc - 1) begin
				wait_rise(n);
				if (i == 0) gap = n;
				chk("gap stable", 16'(n), 16'(gap));
			end
		end
		tick(3);
		chk("group end", {14'h0000, ast, flag}, 16'h0001);
		chk("accumulated", {hi, lo}, sum);
		chk("irq gated", {15'h0000, irq}, 16'h0000);
		ctrl.auto_start <= 1'b0;
		ctrl.irq_clear <= 1'b1;
		tick(2);
		ctrl.irq_clear <= 1'b0;
		$display("test auto done");
	endtask
	// stop in mid-conversion, then relaunch
	task automatic t_stop();
		int n;
		@(posedge sys_clk_in);
		ctrl.count_sel <= 3'h3;
		ctrl.interval_sel <= 4'h0;
		ctrl.auto_start <= 1'b1;
		wait_rise(n);
		tick(3);
		ctrl.auto_start <= 1'b0;
		tick(1);
		conv_len(12);
		wait_rise(n);
		chk("no conversion after stop", 16'(n), 16'd200);
		t_auto(3'h1, 4'h0, 2, 16'h1000, n);
		$display("test stop done");
	endtask
	initial begin
		#40000;
		err_total++;
		conclude();
	end
	initial begin
		tick(3);
		reset_n_in <= 1'b1;
		tick(1);
		t_reset();
		t_manual();
		t_auto(3'h1, 4'h0, 2, 16'h1000, g0);
		t_auto(3'h2, 4'h2, 4, 16'h2000, g1);
		chk("interval step", 16'(g1 - g0), 16'd8);
		t_stop();
		conclude();
	end
endmodule
`default_nettype wire
